// ==== flow_fifo.sv ====
/*
 Byte FIFO, 64 entries, with a run-time depth limit of 16 or 64.
 Ignores a push when full and a pop when empty.
*/
`timescale 1ns/1ps
`default_nettype none
module flow_fifo
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    // Control
    input  wire logic       i_flush,
    input  wire logic [6:0] i_limit,
    // Write side
    input  wire logic       i_push,
    input  wire logic [7:0] i_wdata,
    // Read side
    input  wire logic       i_pop,
    output logic      [7:0] o_rdata,
    output logic      [6:0] o_count,
    output logic            o_full,
    output logic            o_empty
);
    logic [7:0] mem [0:63];
    logic [5:0] wptr;
    logic [5:0] rptr;
    logic [6:0] count;
    logic [5:0] next_wptr;
    logic [5:0] next_rptr;
    logic [6:0] next_count;
    logic       do_push;
    logic       do_pop;

    always_comb
    begin
        do_push    = i_push && (count < i_limit);
        do_pop     = i_pop && (count != 7'h00);
        next_wptr  = wptr + 6'(do_push);
        next_rptr  = rptr + 6'(do_pop);
        next_count = count + 7'(do_push) - 7'(do_pop);
        if (i_flush)
        begin
            next_wptr  = 6'h00;
            next_rptr  = 6'h00;
            next_count = 7'h00;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            wptr  <= 6'h00;
            rptr  <= 6'h00;
            count <= 7'h00;
        end
        else
        begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            count <= next_count;
        end
    end

    // Storage has no reset: contents are don't-care until written
    always_ff @(posedge i_core_clk)
    begin
        if (do_push && !i_flush)
            mem[wptr] <= i_wdata;
    end

    assign o_rdata = mem[rptr];
    assign o_count = count;
    assign o_full  = (count >= i_limit);
    assign o_empty = (count == 7'h00);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
 Self-checking bench for uart_flow_bypass.
 Assumes the checker and the serial stand-in compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_flow_map.svh"
module tb_top;
    logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_extend_n = 1'b0, i_cts_n = 1'b0, slow = 1'b0;
    logic [2:0] i_host_addr = 3'h0;
    logic [11:0] i_sub_addr = 12'h000;
    logic i_host_wr = 1'b0, i_host_rd = 1'b0, i_sub_wr = 1'b0, i_sub_rd = 1'b0;
    logic [7:0] i_host_wdata = 8'h00, i_sub_wdata = 8'h00, i_rx_data = 8'h00;
    logic i_rx_valid = 1'b0, i_rx_parity_err = 1'b0, i_rx_frame_err = 1'b0, i_rx_break = 1'b0;
    wire i_tx_done, o_rts_n, o_tx_start, o_rx_data_avail, o_line_status_int, o_bypass_active;
    wire [7:0] o_host_rdata, o_sub_rdata, o_tx_data;
    int miscompares = 0, n_checks = 0, seed = 3, i, k, r;
    logic [7:0] q [4];
    logic [7:0] fcr_t [4] = '{8'h10, 8'h30, 8'h30, 8'h20};
    logic ext_t [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    int n_t [4] = '{14, 56, 16, 56};
    always #20 i_core_clk = ~i_core_clk;
    uart_flow_bypass dut (.*);
    uart_serial_model far (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_tx_start(o_tx_start), .i_slow(slow), .o_tx_done(i_tx_done));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hacc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        {i_host_wr, i_host_rd, i_host_addr, i_host_wdata} = {w, !w, a, d};
        @(negedge i_core_clk);
        {i_host_wr, i_host_rd} = 2'b00;
    endtask
    task automatic sacc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        {i_sub_wr, i_sub_rd, i_sub_addr, i_sub_wdata} = {w, !w, a, d};
        @(negedge i_core_clk);
        {i_sub_wr, i_sub_rd} = 2'b00;
    endtask
    task automatic rxb(input logic [7:0] d, input logic [2:0] e);
        @(negedge i_core_clk);
        {i_rx_valid, i_rx_data, i_rx_parity_err, i_rx_frame_err, i_rx_break} = {1'b1, d, e};
        @(negedge i_core_clk);
        {i_rx_valid, i_rx_parity_err, i_rx_frame_err, i_rx_break} = 4'h0;
    endtask
    function automatic logic exp_rts(input logic [7:0] f, input logic e, input int c);
        exp_rts = f[4] && !e && c >= (f[5] ? 56 : 14);
    endfunction
    task automatic stop_test;
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Whole run needs under 2000 cycles
    initial
    begin
        #800000;
        miscompares++;
        stop_test();
    end
    initial
    begin
        repeat (5) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        chk(o_bypass_active, 1'b0);
        sacc(1'b0, `SUB_FIFO_ADDR, 8'h00);
        chk(o_sub_rdata, 8'h00);
        sacc(1'b1, `SUB_CTRL_ADDR, 8'h80);
        chk(o_bypass_active, 1'b1);
        for (i = 0; i < 4; i++)
        begin
            q[i] = 8'($random(seed));
            hacc(1'b1, `HOST_DATA_ADDR, q[i]);
        end
        // Serial byte with a parity fault must not land in the FIFO
        rxb(8'h5a, 3'b111);
        chk(o_line_status_int, 1'b0);
        chk(o_rx_data_avail, 1'b0);
        for (i = 0; i < 4; i++)
        begin
            sacc(1'b0, `SUB_FIFO_ADDR, 8'h00);
            chk(o_sub_rdata, q[i]);
        end
        for (i = 0; i < 4; i++)
            sacc(1'b1, `SUB_FIFO_ADDR, ~q[i]);
        chk(o_rx_data_avail, 1'b1);
        for (i = 0; i < 4; i++)
        begin
            hacc(1'b0, `HOST_DATA_ADDR, 8'h00);
            chk(o_host_rdata, ~q[i]);
        end
        chk(o_rx_data_avail, 1'b0);
        sacc(1'b1, `SUB_CTRL_ADDR, 8'h00);
        for (r = 0; r < 4; r++)
        begin
            i_extend_n = ext_t[r];
            hacc(1'b1, `HOST_FCR_ADDR, fcr_t[r] | 8'h06);
            hacc(1'b1, `HOST_MCR_ADDR, 8'h02);
            for (i = 1; i <= n_t[r]; i++)
            begin
                k = $random(seed);
                rxb(8'($random(seed)), 3'(k));
                chk(o_line_status_int, |k[2:0]);
                repeat (2) @(negedge i_core_clk);
                chk(o_rts_n, exp_rts(fcr_t[r], ext_t[r], i));
            end
            hacc(1'b0, `HOST_DATA_ADDR, 8'h00);
            hacc(1'b1, `HOST_MCR_ADDR, 8'h02);
            repeat (2) @(negedge i_core_clk);
            chk(o_rts_n, 1'b0);
            chk(o_rx_data_avail, 1'b1);
        end
        i_extend_n = 1'b0;
        sacc(1'b1, `SUB_MCR_WR_ADDR, 8'h20);
        hacc(1'b1, `HOST_MCR_ADDR, 8'h00);
        sacc(1'b0, `SUB_MCR_RD_ADDR, 8'h00);
        chk(o_sub_rdata & 8'h20, 8'h20);
        i_cts_n = 1'b1;
        for (i = 0; i < 2; i++)
        begin
            q[i] = 8'($random(seed));
            hacc(1'b1, `HOST_DATA_ADDR, q[i]);
        end
        // Outside bypass the port reads zero and must not pop
        sacc(1'b0, `SUB_FIFO_ADDR, 8'h00);
        chk(o_sub_rdata, 8'h00);
        repeat (10) @(negedge i_core_clk);
        chk(o_tx_start, 1'b0);
        i_cts_n = 1'b0;
        for (i = 0; i < 2; i++)
        begin
            slow = i[0];
            for (k = 0; k < 60 && o_tx_start !== 1'b1; k++)
                @(negedge i_core_clk);
            chk(o_tx_start, 1'b1);
            chk(o_tx_data, q[i]);
            i_cts_n = 1'b1;
            @(negedge i_core_clk);
            chk(o_tx_start, 1'b1);
            for (k = 0; k < 60 && o_tx_start === 1'b1; k++)
                @(negedge i_core_clk);
            repeat (10) @(negedge i_core_clk);
            chk(o_tx_start, 1'b0);
            i_cts_n = 1'b0;
        end
        stop_test();
    end
endmodule
bind uart_flow_bypass uart_flow_chk chk (.*);
`default_nettype wire

// ==== uart_flow_bypass.sv ====
/*
 Flow-control and serial-bypass logic around the UART FIFOs.
 Assumes host and subsystem strobes are one-cycle pulses synchronous
 to the core clock, and a serial engine that handshakes one byte at a time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_flow_map.svh"
module uart_flow_bypass
(
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    // Pins
    input  wire logic        i_extend_n,
    input  wire logic        i_cts_n,
    output logic             o_rts_n,
    // Host register port
    input  wire logic [2:0]  i_host_addr,
    input  wire logic        i_host_wr,
    input  wire logic        i_host_rd,
    input  wire logic [7:0]  i_host_wdata,
    output logic      [7:0]  o_host_rdata,
    // Subsystem register port
    input  wire logic [11:0] i_sub_addr,
    input  wire logic        i_sub_wr,
    input  wire logic        i_sub_rd,
    input  wire logic [7:0]  i_sub_wdata,
    output logic      [7:0]  o_sub_rdata,
    // Serial receiver
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_data,
    input  wire logic        i_rx_parity_err,
    input  wire logic        i_rx_frame_err,
    input  wire logic        i_rx_break,
    // Serial transmitter
    input  wire logic        i_tx_done,
    output logic             o_tx_start,
    output logic      [7:0]  o_tx_data,
    // Interrupt sources to host interrupt logic
    output logic             o_rx_data_avail,
    output logic             o_line_status_int,
    output logic             o_bypass_active
);
    logic [7:0] ctrl;
    logic [7:0] subsystem_modem_control_write;
    logic [7:0] fifo_control_reg;
    logic [7:0] next_ctrl;
    logic [7:0] next_mcr;
    logic [7:0] next_fcr;
    logic [7:0] tx_data;
    logic [7:0] next_tx_data;
    logic [7:0] sub_rdata;
    logic [7:0] next_sub_rdata;
    logic [7:0] host_rdata;
    logic [7:0] next_host_rdata;
    logic       line_int;
    logic       next_line_int;
    uart_flow_pkg::tx_state_e tx_state;
    uart_flow_pkg::tx_state_e next_tx_state;

    logic       bypass;
    logic       deep;
    logic       auto_rts;
    logic       auto_cts;
    logic [6:0] limit;
    logic [6:0] rx_count;
    logic [6:0] tx_count;
    logic [6:0] trigger;
    logic [7:0] rx_rdata;
    logic [7:0] tx_rdata;
    logic       rx_full;
    logic       rx_empty;
    logic       tx_full;
    logic       tx_empty;
    logic       rx_push;
    logic       rx_pop;
    logic       tx_push;
    logic       tx_pop;
    logic [7:0] rx_wdata;
    logic       fcr_wr;
    logic       sub_fifo_wr;
    logic       sub_fifo_rd;
    logic       host_data_rd;
    logic       start;

    function automatic logic sub_hit(input logic [11:0] addr, input logic [11:0] reg_addr);
        sub_hit = (addr == reg_addr);
    endfunction

    // Mode decode
    assign bypass   = ctrl[`CTRL_BYPASS_BIT];
    assign deep     = fifo_control_reg[`FCR_DEEP_BIT] && !i_extend_n;
    assign limit    = deep ? `DEPTH_DEEP : `DEPTH_SHALLOW;
    assign auto_rts = fifo_control_reg[`FCR_ARTS_BIT] && !i_extend_n;
    assign auto_cts = subsystem_modem_control_write[`MCR_ACTS_BIT];

    assign fcr_wr       = i_host_wr && (i_host_addr == `HOST_FCR_ADDR);
    assign host_data_rd = i_host_rd && (i_host_addr == `HOST_DATA_ADDR);
    assign sub_fifo_wr  = i_sub_wr && sub_hit(i_sub_addr, `SUB_FIFO_ADDR);
    assign sub_fifo_rd  = i_sub_rd && sub_hit(i_sub_addr, `SUB_FIFO_ADDR);

    // Serial path gated off in bypass; subsystem owns the serial end of both FIFOs
    assign rx_push  = bypass ? sub_fifo_wr : i_rx_valid;
    assign rx_wdata = bypass ? i_sub_wdata : i_rx_data;
    assign rx_pop   = host_data_rd;
    assign tx_push  = i_host_wr && (i_host_addr == `HOST_DATA_ADDR);
    assign tx_pop   = bypass ? sub_fifo_rd : start;

    flow_fifo u_rx_fifo
    (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_flush    (fcr_wr && i_host_wdata[1]),
        .i_limit    (limit),
        .i_push     (rx_push),
        .i_wdata    (rx_wdata),
        .i_pop      (rx_pop),
        .o_rdata    (rx_rdata),
        .o_count    (rx_count),
        .o_full     (rx_full),
        .o_empty    (rx_empty)
    );

    flow_fifo u_tx_fifo
    (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_flush    (fcr_wr && i_host_wdata[2]),
        .i_limit    (limit),
        .i_push     (tx_push),
        .i_wdata    (i_host_wdata),
        .i_pop      (tx_pop),
        .o_rdata    (tx_rdata),
        .o_count    (tx_count),
        .o_full     (tx_full),
        .o_empty    (tx_empty)
    );

    // Trigger level for data-available, independent of auto-RTS
    always_comb
    begin
        unique case ({fifo_control_reg[`FCR_TRIG_HI_BIT], fifo_control_reg[`FCR_TRIG_LO_BIT]})
            2'b00:   trigger = 7'h01;
            2'b01:   trigger = deep ? 7'h10 : 7'h04;
            2'b10:   trigger = deep ? 7'h20 : 7'h08;
            2'b11:   trigger = deep ? 7'h38 : 7'h0e;
        endcase
    end

    // Transmit sequencer
    always_comb
    begin
        next_tx_state = tx_state;
        next_tx_data  = tx_data;
        start         = 1'b0;
        unique case (tx_state)
            uart_flow_pkg::TX_IDLE:
            begin
                // Halt only between characters, never mid-character
                if (!bypass && !tx_empty && !(auto_cts && i_cts_n))
                begin
                    start         = 1'b1;
                    next_tx_data  = tx_rdata;
                    next_tx_state = uart_flow_pkg::TX_SEND;
                end
            end
            uart_flow_pkg::TX_SEND:
            begin
                if (i_tx_done)
                    next_tx_state = uart_flow_pkg::TX_IDLE;
            end
            default:
                next_tx_state = uart_flow_pkg::TX_IDLE;
        endcase
    end

    // Register writes and automatic RTS clear
    always_comb
    begin
        next_ctrl = ctrl;
        next_mcr  = subsystem_modem_control_write;
        next_fcr  = fifo_control_reg;
        if (i_sub_wr && sub_hit(i_sub_addr, `SUB_CTRL_ADDR))
            next_ctrl = {i_sub_wdata[7], 1'b0, i_sub_wdata[5:0]};
        if (fcr_wr)
            next_fcr = i_host_wdata;
        if (i_host_wr && (i_host_addr == `HOST_MCR_ADDR))
            next_mcr = {subsystem_modem_control_write[7:6], subsystem_modem_control_write[5], i_host_wdata[4:0]};
        if (i_sub_wr && sub_hit(i_sub_addr, `SUB_MCR_WR_ADDR))
            next_mcr[`MCR_ACTS_BIT] = i_sub_wdata[`MCR_ACTS_BIT];
        // Hardware clear wins over a host set in the same cycle
        if (auto_rts
            && (rx_count >= (deep ? `RTS_STOP_DEEP : `RTS_STOP_SHALLOW)))
            next_mcr[`MCR_RTS_BIT] = 1'b0;
        // Next bypass too, so no pulse lands in the first bypass cycle
        next_line_int = !bypass && !next_ctrl[`CTRL_BYPASS_BIT] && i_rx_valid
                        && (i_rx_parity_err || i_rx_frame_err || i_rx_break);
        next_sub_rdata = 8'h00;
        if (sub_fifo_rd && bypass)
            next_sub_rdata = tx_rdata;
        else if (i_sub_rd && sub_hit(i_sub_addr, `SUB_MCR_RD_ADDR))
            next_sub_rdata = subsystem_modem_control_write;
        else if (i_sub_rd && sub_hit(i_sub_addr, `SUB_CTRL_ADDR))
            next_sub_rdata = ctrl;
        next_host_rdata = host_rdata;
        if (host_data_rd)
            next_host_rdata = rx_rdata;
        else if (i_host_rd && (i_host_addr == `HOST_MCR_ADDR))
            next_host_rdata = subsystem_modem_control_write;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            ctrl       <= `CTRL_RESET;
            subsystem_modem_control_write        <= `MCR_RESET;
            fifo_control_reg        <= `FCR_RESET;
            tx_state   <= uart_flow_pkg::TX_IDLE;
            tx_data    <= 8'h00;
            sub_rdata  <= 8'h00;
            host_rdata <= 8'h00;
            line_int   <= 1'b0;
        end
        else
        begin
            ctrl       <= next_ctrl;
            subsystem_modem_control_write        <= next_mcr;
            fifo_control_reg        <= next_fcr;
            tx_state   <= next_tx_state;
            tx_data    <= next_tx_data;
            sub_rdata  <= next_sub_rdata;
            host_rdata <= next_host_rdata;
            line_int   <= next_line_int;
        end
    end

    assign o_rts_n           = !subsystem_modem_control_write[`MCR_RTS_BIT];
    assign o_tx_start        = (tx_state == uart_flow_pkg::TX_SEND);
    assign o_tx_data         = tx_data;
    assign o_host_rdata      = host_rdata;
    assign o_sub_rdata       = sub_rdata;
    // Same trigger compare whatever the CTS/RTS modes
    assign o_rx_data_avail   = (rx_count >= trigger);
    assign o_line_status_int = line_int;
    assign o_bypass_active   = bypass;
endmodule
`default_nettype wire

// ==== uart_flow_chk.sv ====
/*
 Port checker for uart_flow_bypass.
 Assumes a bind by port name from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_flow_map.svh"
module uart_flow_chk
(
    // Watched ports
    input wire logic        i_core_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_cts_n,
    input wire logic [11:0] i_sub_addr,
    input wire logic        i_sub_wr,
    input wire logic        i_sub_rd,
    input wire logic [7:0]  i_sub_wdata,
    input wire logic [7:0]  o_sub_rdata,
    input wire logic        i_rx_valid,
    input wire logic        i_rx_parity_err,
    input wire logic        i_tx_done,
    input wire logic        o_tx_start,
    input wire logic        o_line_status_int,
    input wire logic        o_bypass_active
);
    // Shadow of the auto-CTS enable, seen only through subsystem writes
    logic acts;
    logic next_acts;
    always_comb
    begin
        next_acts = acts;
        if (i_sub_wr && i_sub_addr == `SUB_MCR_WR_ADDR)
            next_acts = i_sub_wdata[`MCR_ACTS_BIT];
    end
    always_ff @(posedge i_core_clk)
        acts <= i_sys_rst ? 1'b0 : next_acts;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    property p_bypass_set;
        i_sub_wr && i_sub_addr == `SUB_CTRL_ADDR |=> o_bypass_active == $past(i_sub_wdata[7]);
    endproperty
    a_bypass_set: assert property (p_bypass_set) else $error("bypass bit not taken");
    property p_bypass_rst; $past(i_sys_rst) |-> !o_bypass_active; endproperty
    a_bypass_rst: assert property (p_bypass_rst) else $error("bypass set after reset");
    property p_no_lsi; o_bypass_active |-> !o_line_status_int; endproperty
    a_no_lsi: assert property (p_no_lsi) else $error("line status raised in bypass");
    property p_lsi;
        i_rx_valid && i_rx_parity_err && !o_bypass_active
        && !(i_sub_wr && i_sub_addr == `SUB_CTRL_ADDR && i_sub_wdata[7])
        |=> o_line_status_int;
    endproperty
    a_lsi: assert property (p_lsi) else $error("line status missing");
    property p_no_tx; o_bypass_active && !o_tx_start |=> !o_tx_start; endproperty
    a_no_tx: assert property (p_no_tx) else $error("serial send in bypass");
    property p_cts_halt; (acts && i_cts_n && !o_tx_start) [*3] |=> !o_tx_start; endproperty
    a_cts_halt: assert property (p_cts_halt) else $error("send while clear low");
    property p_cts_keep; o_tx_start && !i_tx_done |=> o_tx_start; endproperty
    a_cts_keep: assert property (p_cts_keep) else $error("character cut short");
    property p_tx_end; o_tx_start && i_tx_done |=> !o_tx_start; endproperty
    a_tx_end: assert property (p_tx_end) else $error("send not ended");
    property p_rd_off;
        i_sub_rd && i_sub_addr == `SUB_FIFO_ADDR && !o_bypass_active |=> o_sub_rdata == 8'h00;
    endproperty
    a_rd_off: assert property (p_rd_off) else $error("fifo read outside bypass");
    c_bypass_rd: cover property (o_bypass_active && i_sub_rd);
    c_cts_send: cover property (acts && i_cts_n && o_tx_start);
    c_lsi: cover property (o_line_status_int);
endmodule
`default_nettype wire

// ==== uart_flow_map.svh ====
/*
 Register offsets, field positions, reset values and FIFO thresholds for
 the flow-control and bypass block. Assumes inclusion by bare name.
*/
`ifndef UART_FLOW_MAP_SVH
`define UART_FLOW_MAP_SVH
`define SUB_CTRL_ADDR     12'h110
`define SUB_MCR_WR_ADDR   12'h130
`define SUB_MCR_RD_ADDR   12'h134
`define SUB_FIFO_ADDR     12'h140
`define HOST_FCR_ADDR     3'h2
`define HOST_MCR_ADDR     3'h4
`define HOST_DATA_ADDR    3'h0
`define CTRL_BYPASS_BIT   7
`define MCR_ACTS_BIT      5
`define MCR_RTS_BIT       1
`define FCR_ARTS_BIT      4
`define FCR_DEEP_BIT      5
`define FCR_TRIG_LO_BIT   6
`define FCR_TRIG_HI_BIT   7
`define RTS_STOP_SHALLOW  7'h0e
`define RTS_STOP_DEEP     7'h38
`define DEPTH_SHALLOW     7'h10
`define DEPTH_DEEP        7'h40
`define MCR_RESET         8'h00
`define FCR_RESET         8'h00
`define CTRL_RESET        8'h00
`endif

// ==== uart_flow_pkg.sv ====
/*
 Types shared by the bypass block. Assumes nothing beyond the compiler.
*/
package uart_flow_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] count_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_HOLD = 3'b100
    } tx_state_e;
endpackage

// ==== uart_serial_model.sv ====
/*
 Serial transmitter stand-in: ends each character after a short or long time.
 Assumes the start level from uart_flow_bypass.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_serial_model
(
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    // Transmit handshake
    input  wire logic i_tx_start,
    input  wire logic i_slow,
    output logic      o_tx_done
);
    logic [4:0] cnt = 5'h00;
    initial o_tx_done = 1'b0;
    // Driven off the falling edge so the design samples settled levels
    always @(negedge i_core_clk)
    begin
        o_tx_done <= 1'b0;
        if (i_sys_rst || !i_tx_start || o_tx_done)
            cnt <= 5'h00;
        else if (cnt == (i_slow ? 5'h1f : 5'h01))
            o_tx_done <= 1'b1;
        else
            cnt <= cnt + 5'h01;
    end
endmodule
`default_nettype wire
